// ---- core/cmfc_pkg.sv ----
// shared constants, state codes and carriers for the charger mode and fault controller
package cmfc_pkg;
  // clock and timing figures
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned RESUME_MS = 110; // delay before charging resumes
  localparam int unsigned RESUME_CYC = RESUME_MS * CLK_MHZ * 1000;
  localparam int unsigned PULSE_US = 128; // event pulse width
  localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int unsigned OVP_DGL_US = 100; // overvoltage deglitch
  localparam int unsigned OVP_DGL_CYC = OVP_DGL_US * CLK_MHZ;
  localparam int unsigned SC_DGL_US = 50; // short circuit deglitch
  localparam int unsigned SC_DGL_CYC = SC_DGL_US * CLK_MHZ;
  localparam int unsigned SC_REC_US = 2000; // short circuit recovery
  localparam int unsigned SC_REC_CYC = SC_REC_US * CLK_MHZ;
  localparam int unsigned BAT_DGL_US = 50; // battery undervoltage deglitch
  localparam int unsigned BAT_DGL_CYC = BAT_DGL_US * CLK_MHZ;
  localparam int unsigned CNT_W = 23; // wide enough for the resume delay
  localparam int unsigned DGL_W = 13; // wide enough for any deglitch count
  // variant codes, also the overvoltage threshold selector
  localparam logic [1:0] VAR_10V5 = 2'h0;
  localparam logic [1:0] VAR_14V = 2'h1;
  localparam logic [1:0] VAR_6V5 = 2'h2;
  // inhibit bit value after reset, indexed by variant code
  localparam logic [3:0] INH_RST_BY_VAR = 4'h2;
  // state and fault codes
  localparam logic [1:0] SC_READY = 2'h0;
  localparam logic [1:0] SC_CHARGING = 2'h1;
  localparam logic [1:0] SC_FAULT = 2'h3;
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_OVP = 3'h1;
  localparam logic [2:0] FC_SLEEP = 3'h2;

  typedef enum logic [2:0] {
    ST_HIZ = 3'h0,
    ST_BATT = 3'h1,
    ST_SC_OFF = 3'h2,
    ST_OVP = 3'h3,
    ST_SLEEP = 3'h4,
    ST_INHIBIT = 3'h5,
    ST_RESUME = 3'h6,
    ST_CHARGE = 3'h7
  } cmfc_state_e;

  // raw comparator and pin levels, asynchronous to the clock
  typedef struct packed {
    logic vin_above_uvlo;
    logic vin_above_sleep;
    logic vin_above_ovp;
    logic vin_at_droop;
    logic bat_above_uvlo;
    logic dischg_over_limit;
    logic chip_disable_pin;
  } cmfc_ana_s;

  // power path controls
  typedef struct packed {
    logic buck_en;
    logic bat_fet_on;
    logic ext_fet_gate;
    logic sysreg_high;
  } cmfc_path_s;

  // host visible status
  typedef struct packed {
    logic [1:0] state_code;
    logic [2:0] fault_code;
    logic droop_flag;
  } cmfc_stat_s;
endpackage

// ---- core/cmfc_filt.sv ----
// two flop synchroniser with a rising edge deglitch counter
`timescale 1ns/10ps
module cmfc_filt #(
  parameter logic [cmfc_pkg::DGL_W-1:0] N = 13'h0001
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // raw level
  input wire logic i_raw,
  // filtered levels
  output logic o_sync,
  output logic o_dgl
);
  import cmfc_pkg::*;

  logic meta_r; // first stage, read only by the second
  logic sync_r; // second stage
  logic [DGL_W-1:0] cnt_r; // cycles the level has stayed high
  logic dgl_r;
  logic [DGL_W-1:0] cnt_nxt;
  wire at_end = (cnt_r == N);

  // count up while high, hold at the end, restart on any low
  assign cnt_nxt = !sync_r ? '0 : (at_end ? cnt_r : cnt_r + 1'b1);

  // falling edge passes at once: only a lasting high is trusted
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      cnt_r <= '0;
      dgl_r <= 1'b0;
    end else begin
      meta_r <= i_raw;
      sync_r <= meta_r;
      cnt_r <= cnt_nxt;
      dgl_r <= sync_r && (cnt_nxt == N);
    end
  end

  assign o_sync = sync_r;
  assign o_dgl = dgl_r;
endmodule

// ---- core/cmfc_ctrl.sv ----
// charger mode sequencing: high impedance, battery only, sleep, overvoltage, droop, inhibit
`timescale 1ns/10ps
module cmfc_ctrl #(
  parameter int unsigned RESUME_CYC_P = cmfc_pkg::RESUME_CYC,
  parameter int unsigned PULSE_CYC_P = cmfc_pkg::PULSE_CYC,
  parameter int unsigned SC_REC_CYC_P = cmfc_pkg::SC_REC_CYC,
  parameter logic [1:0] VARIANT = cmfc_pkg::VAR_10V5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // analog comparators and the disable pin, asynchronous
  input wire cmfc_pkg::cmfc_ana_s i_ana,
  // host control bits
  input wire logic i_hiz_req,
  input wire logic i_dbl_timer,
  input wire logic i_inh_wr,
  input wire logic i_inh_wdata,
  input wire logic i_fault_read,
  // power path
  output cmfc_pkg::cmfc_path_s o_path,
  // status and event pins
  output cmfc_pkg::cmfc_stat_s o_stat,
  output logic o_stat_pulse,
  output logic o_int_pulse,
  // charge engine controls
  output logic o_charge_start,
  output logic o_timer_reset,
  output logic o_timer_extend,
  output logic o_term_en,
  output logic o_chg_cur_reduce,
  output logic o_charge_inhibit,
  output logic [1:0] o_ovp_sel
);
  import cmfc_pkg::*;

  // synchronised and deglitched inputs
  logic uvlo_s, sleep_s, ovp_s, droop_s, cd_s;
  logic ovp_dgl, bat_dgl, sc_dgl;

  // pins pass two flops before use, deglitch where timing matters
  cmfc_filt #(.N(13'h0001)) u_uvlo (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.vin_above_uvlo),
    .o_sync(uvlo_s), .o_dgl());
  cmfc_filt #(.N(13'h0001)) u_sleep (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.vin_above_sleep),
    .o_sync(sleep_s), .o_dgl());
  cmfc_filt #(.N(13'h0001)) u_droop (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.vin_at_droop),
    .o_sync(droop_s), .o_dgl());
  cmfc_filt #(.N(13'h0001)) u_cd (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.chip_disable_pin),
    .o_sync(cd_s), .o_dgl());
  cmfc_filt #(.N(DGL_W'(OVP_DGL_CYC))) u_ovp (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.vin_above_ovp),
    .o_sync(ovp_s), .o_dgl(ovp_dgl));
  cmfc_filt #(.N(DGL_W'(BAT_DGL_CYC))) u_bat (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.bat_above_uvlo),
    .o_sync(), .o_dgl(bat_dgl));
  cmfc_filt #(.N(DGL_W'(SC_DGL_CYC))) u_sc (
    .i_clk(i_clk), .i_rst(i_rst), .i_raw(i_ana.dischg_over_limit),
    .o_sync(), .o_dgl(sc_dgl));

  // state and counters
  cmfc_state_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt; // dwell time in the current state
  logic [CNT_W-1:0] pls_r, pls_nxt; // remaining event pulse cycles
  logic inh_r, inh_nxt; // charge inhibit bit
  cmfc_stat_s stat_nxt;
  cmfc_path_s path_nxt;

  // mode causes, in priority order
  wire no_input = !uvlo_s; // undervoltage, battery feeds the rail
  wire hiz_force = i_hiz_req | cd_s;
  wire ovp_hold = ovp_dgl | ((st_r == ST_OVP) & ovp_s);
  wire sleep_cond = !sleep_s; // input under battery plus offset
  wire inh_wr0 = i_inh_wr & !i_inh_wdata;
  wire cnt_end_res = (cnt_r == CNT_W'(RESUME_CYC_P - 1));
  wire cnt_end_rec = (cnt_r == CNT_W'(SC_REC_CYC_P - 1));
  // valid input: above undervoltage, above sleep, below overvoltage
  wire in_valid = !no_input & !hiz_force & !ovp_hold & !sleep_cond;
  wire go_chg = inh_r ? 1'b0 : 1'b1;
  wire ev_sleep = (st_nxt == ST_SLEEP) & (st_r != ST_SLEEP);
  wire ev_ovp = (st_nxt == ST_OVP) & (st_r != ST_OVP);
  wire droop_act = (st_nxt == ST_CHARGE) & droop_s;

  // host written inhibit bit; a new value takes effect next cycle
  assign inh_nxt = i_inh_wr ? i_inh_wdata : inh_r;

  // next state: causes first, then the per state sequence
  always_comb begin
    st_nxt = st_r;
    if (no_input) begin
      // undervoltage is a high impedance cause; battery path rules apply
      if (st_r != ST_BATT && st_r != ST_SC_OFF) begin
        st_nxt = ST_BATT;
      end else if (st_r == ST_BATT && bat_dgl && sc_dgl) begin
        st_nxt = ST_SC_OFF;
      end else if (st_r == ST_SC_OFF && cnt_end_rec) begin
        st_nxt = ST_BATT; // retest the short
      end
    end else if (hiz_force) begin
      st_nxt = ST_HIZ;
    end else if (ovp_hold) begin
      st_nxt = ST_OVP;
    end else if (sleep_cond) begin
      st_nxt = ST_SLEEP;
    end else begin
      case (st_r)
        ST_HIZ, ST_BATT, ST_SC_OFF: begin
          st_nxt = ST_RESUME; // leaving high impedance waits first
        end
        ST_RESUME: begin
          if (cnt_end_res) begin
            st_nxt = go_chg ? ST_CHARGE : ST_INHIBIT;
          end
        end
        ST_OVP, ST_SLEEP: begin
          st_nxt = go_chg ? ST_CHARGE : ST_INHIBIT;
        end
        ST_INHIBIT: begin
          if (inh_wr0) begin
            st_nxt = ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (i_inh_wr && i_inh_wdata) begin
            st_nxt = ST_INHIBIT; // host stops the cycle
          end
        end
        default: begin
          st_nxt = ST_HIZ;
        end
      endcase
    end
  end

  // dwell counter restarts on every state change
  assign cnt_nxt = (st_nxt != st_r) ? '0 : cnt_r + 1'b1;

  // event pulse: one load per entry, a second event restarts it
  assign pls_nxt = (ev_sleep | ev_ovp) ? CNT_W'(PULSE_CYC_P)
                 : (pls_r != '0) ? pls_r - 1'b1 : '0;

  // power path per state; overvoltage kills the buck without deglitch
  always_comb begin
    path_nxt = '0;
    case (st_nxt)
      ST_HIZ, ST_OVP, ST_SLEEP: begin
        path_nxt.bat_fet_on = 1'b1;
        path_nxt.ext_fet_gate = 1'b1;
      end
      ST_BATT: begin
        path_nxt.bat_fet_on = bat_dgl;
        path_nxt.ext_fet_gate = bat_dgl;
      end
      ST_SC_OFF: begin
        path_nxt.bat_fet_on = 1'b0;
      end
      ST_INHIBIT, ST_RESUME: begin
        path_nxt.buck_en = 1'b1;
        path_nxt.sysreg_high = 1'b1;
      end
      ST_CHARGE: begin
        path_nxt.buck_en = 1'b1;
        path_nxt.bat_fet_on = 1'b1;
      end
      default: begin
        path_nxt = '0;
      end
    endcase
    if (ovp_s) begin
      path_nxt.buck_en = 1'b0;
    end
  end

  // status codes: state code follows the mode, fault code is sticky
  always_comb begin
    stat_nxt.droop_flag = droop_act;
    case (st_nxt)
      ST_CHARGE: stat_nxt.state_code = SC_CHARGING;
      ST_SLEEP, ST_OVP: stat_nxt.state_code = SC_FAULT;
      default: stat_nxt.state_code = SC_READY;
    endcase
    // a new event wins over a read in the same cycle
    if (ev_ovp) begin
      stat_nxt.fault_code = FC_OVP;
    end else if (ev_sleep) begin
      stat_nxt.fault_code = FC_SLEEP;
    end else if (i_fault_read && (st_nxt != ST_OVP) && (st_nxt != ST_SLEEP)) begin
      stat_nxt.fault_code = FC_NONE;
    end else begin
      stat_nxt.fault_code = o_stat.fault_code;
    end
  end

  // state, counters and inhibit bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= ST_HIZ;
      cnt_r <= '0;
      pls_r <= '0;
      inh_r <= INH_RST_BY_VAR[VARIANT];
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pls_r <= pls_nxt;
      inh_r <= inh_nxt;
    end
  end

  // every output is a flop fed from the next values above, except o_ovp_sel, which reloads VARIANT
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_path <= 4'h6; // reset state is high impedance: both fets on
      o_stat <= '0;
      o_stat_pulse <= 1'b0;
      o_int_pulse <= 1'b0;
      o_charge_start <= 1'b0;
      o_timer_reset <= 1'b0;
      o_timer_extend <= 1'b0;
      o_term_en <= 1'b0;
      o_chg_cur_reduce <= 1'b0;
      o_charge_inhibit <= INH_RST_BY_VAR[VARIANT];
      o_ovp_sel <= VARIANT;
    end else begin
      o_path <= path_nxt;
      o_stat <= stat_nxt;
      o_stat_pulse <= (pls_nxt != '0);
      o_int_pulse <= (pls_nxt != '0);
      o_charge_start <= (st_nxt == ST_CHARGE) & ((st_r != ST_CHARGE) | inh_wr0);
      o_timer_reset <= ((st_nxt == ST_HIZ) | (st_nxt == ST_BATT)) & (st_r == ST_HIZ ?
                       1'b0 : (st_r != ST_BATT) & (st_r != ST_SC_OFF));
      o_timer_extend <= droop_act & i_dbl_timer;
      o_term_en <= (st_nxt == ST_CHARGE) & !droop_act;
      o_chg_cur_reduce <= droop_act;
      o_charge_inhibit <= inh_nxt;
      o_ovp_sel <= VARIANT;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_resume_done;
    (st_r == ST_RESUME) ##1 (st_r == ST_CHARGE || st_r == ST_INHIBIT);
  endsequence

  sequence s_hiz_enter;
    !(st_r inside {ST_HIZ, ST_BATT, ST_SC_OFF}) ##1 (st_r inside {ST_HIZ, ST_BATT});
  endsequence

  property p_hiz_entry;
    (hiz_force && !no_input && st_r != ST_HIZ) |=> (st_r == ST_HIZ);
  endproperty
  a_hiz_entry: assert property (p_hiz_entry) else $error("high impedance not entered");

  property p_hiz_path;
    (st_r == ST_HIZ) |-> (!o_path.buck_en && o_path.bat_fet_on && o_path.ext_fet_gate);
  endproperty
  a_hiz_path: assert property (p_hiz_path) else $error("high impedance path wrong");

  property p_timer_reset;
    s_hiz_enter |-> o_timer_reset;
  endproperty
  a_timer_reset: assert property (p_timer_reset) else $error("safety timer not reset");

  property p_resume;
    s_resume_done |-> ($past(cnt_r, 1) == CNT_W'(RESUME_CYC_P - 1));
  endproperty
  a_resume: assert property (p_resume) else $error("resume delay wrong");

  property p_sc_off;
    $rose(st_r == ST_SC_OFF) |-> ($past(sc_dgl) && !o_path.bat_fet_on);
  endproperty
  a_sc_off: assert property (p_sc_off) else $error("short recovery wrong");

  property p_pulse_start;
    $rose(o_int_pulse) |-> (pls_r == CNT_W'(PULSE_CYC_P)) && o_stat_pulse;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("event pulse length");

  property p_ovp_event;
    $rose(st_r == ST_OVP) |-> o_int_pulse && o_stat.fault_code == FC_OVP
      && o_stat.state_code == SC_FAULT && o_path.bat_fet_on;
  endproperty
  a_ovp_event: assert property (p_ovp_event) else $error("overvoltage entry wrong");

  property p_ovp_buck;
    ovp_s |=> !o_path.buck_en;
  endproperty
  a_ovp_buck: assert property (p_ovp_buck) else $error("buck on in overvoltage");

  property p_fault_hold;
    (o_stat.fault_code != FC_NONE && !i_fault_read) |=> (o_stat.fault_code != FC_NONE);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault code lost");

  property p_inhibit;
    (st_r == ST_INHIBIT) |-> (!o_path.bat_fet_on && o_path.sysreg_high);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit path wrong");

  property p_start;
    (st_r == ST_INHIBIT && inh_wr0 && in_valid) |=> o_charge_start ##1 !o_charge_start;
  endproperty
  a_start: assert property (p_start) else $error("charge start missing");

  property p_droop;
    (droop_s && st_nxt == ST_CHARGE) |=> o_chg_cur_reduce && !o_term_en && o_stat.droop_flag
      && (o_timer_extend == $past(i_dbl_timer));
  endproperty
  a_droop: assert property (p_droop) else $error("droop handling wrong");
endmodule

// ---- verification/cmfc_supply_model.sv ----
// input supply and battery model turning voltages into comparator levels
`timescale 1ns/10ps
module cmfc_supply_model #(
  parameter logic [15:0] UVLO_MV = 16'h0ED8, // plain default, not a device figure
  parameter logic [15:0] SLP_MV = 16'h0028, // sleep offset above the battery
  parameter logic [15:0] DROOP_MV = 16'h1068,
  parameter logic [15:0] OVP_MV = 16'h36B0, // 14 V variant
  parameter logic [15:0] BATUV_MV = 16'h0BB8 // plain default
) (
  // bench controlled sources
  input wire logic [15:0] i_vin_mv,
  input wire logic [15:0] i_bat_mv,
  input wire logic i_short,
  input wire logic i_cd,
  // controller feedback: battery fet state
  input wire logic i_fet_on,
  // comparator levels toward the controller
  output cmfc_pkg::cmfc_ana_s o_ana
);
  import cmfc_pkg::*;
  // each comparator is a plain level; the design must synchronise them
  wire logic uv_ok = i_vin_mv > UVLO_MV;
  wire logic slp_ok = i_vin_mv > (i_bat_mv + SLP_MV);
  wire logic ovp = i_vin_mv > OVP_MV;
  wire logic droop = uv_ok && (i_vin_mv <= DROOP_MV);
  wire logic bat_ok = i_bat_mv > BATUV_MV;
  // a short only pulls current while the battery fet is on, so a retest must deglitch again
  wire logic dischg = i_short && i_fet_on;
  assign o_ana = {uv_ok, slp_ok, ovp, droop, bat_ok, dischg, i_cd};
endmodule

// ---- verification/cmfc_ctrl_test.sv ----
// self-checking bench for the charger mode and fault controller
`timescale 1ns/10ps
module cmfc_ctrl_test;
  import cmfc_pkg::*;
  localparam int RES = 50; // shortened resume delay
  localparam int PUL = 8; // shortened event pulse
  localparam int REC = 20; // shortened short recovery
  logic i_clk, i_rst, shrt, cd, hiz, dbl, inh_wr, inh_wd, frd;
  logic [15:0] vin, bat;
  cmfc_ana_s ana;
  cmfc_path_s path;
  cmfc_stat_s stat;
  logic spul, ipul, cstart, trst, text, term, cred, inh;
  logic [1:0] osel;
  int fail_count, compares, n, k;
  logic [31:0] seed, rnd;
  cmfc_supply_model env_u (.i_vin_mv(vin), .i_bat_mv(bat), .i_short(shrt), .i_cd(cd),
    .i_fet_on(path.bat_fet_on), .o_ana(ana));
  cmfc_ctrl #(.RESUME_CYC_P(RES), .PULSE_CYC_P(PUL), .SC_REC_CYC_P(REC), .VARIANT(VAR_14V))
    dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ana(ana), .i_hiz_req(hiz), .i_dbl_timer(dbl),
    .i_inh_wr(inh_wr), .i_inh_wdata(inh_wd), .i_fault_read(frd), .o_path(path),
    .o_stat(stat), .o_stat_pulse(spul), .o_int_pulse(ipul), .o_charge_start(cstart),
    .o_timer_reset(trst), .o_timer_extend(text), .o_term_en(term),
    .o_chg_cur_reduce(cred), .o_charge_inhibit(inh), .o_ovp_sel(osel));
  // free running clock
  always #12.5 i_clk = ~i_clk;
  // repeatable random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected path: 1 for high impedance or fault, 0 for resume or inhibit
  function automatic cmfc_path_s exp_path(input logic off_line);
    return off_line ? 4'h6 : 4'h9;
  endfunction
  // one compare, counted
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // step past edges so flop updates have landed
  task automatic adv(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  // observed signal picked by number
  function automatic logic sig(input int s);
    case (s)
      0: return path.buck_en;
      1: return path.bat_fet_on;
      2: return cstart;
      3: return spul;
      default: return trst;
    endcase
  endfunction
  // bounded wait for a level; running out counts as a mismatch
  task automatic wait_on(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (sig(s) !== v && c < lim) begin
      adv(1);
      c++;
    end
    if (c >= lim) chk(8'h00, 8'h01);
  endtask
  // width of an event pulse, both pins together
  task automatic cnt_pulse(output int c);
    c = 0;
    while (spul === 1'b1 && c < 1000) begin
      if (ipul !== 1'b1) chk(8'h00, 8'h01);
      adv(1);
      c++;
    end
  endtask
  // supply change made at a rising edge
  task automatic set_vin(input logic [15:0] mv);
    @(posedge i_clk);
    vin <= mv;
    #1;
  endtask
  // host write of the inhibit bit, one cycle strobe
  task automatic host_wr(input logic v);
    @(posedge i_clk);
    inh_wr <= 1'b1;
    inh_wd <= v;
    @(posedge i_clk);
    inh_wr <= 1'b0;
    #1;
  endtask
  // host read of the fault code, one cycle strobe
  task automatic host_rd();
    @(posedge i_clk);
    frd <= 1'b1;
    @(posedge i_clk);
    frd <= 1'b0;
    adv(2);
  endtask
  // closing point of the run
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard sized well above the planned traffic
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    {i_clk, shrt, cd, hiz, dbl, inh_wr, inh_wd, frd} = '0;
    i_rst = 1'b1;
    vin = 16'h0000;
    // battery above the undervoltage level so a sleep window exists
    bat = 16'h0FA0;
    seed = 32'h9C29;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk(inh, 1'b1);
    chk(osel, VAR_14V);
    chk(path, exp_path(1'b1));
    chk(stat, 6'h00);
    // battery only: the FET waits for the battery deglitch
    adv(20);
    chk(path.bat_fet_on, 1'b0);
    wait_on(1, 1'b1, 2100, n);
    chk(n > 1900, 1'b1);
    chk(path.buck_en, 1'b0);
    // short held on: off, recover, retest, off again
    @(posedge i_clk) shrt <= 1'b1;
    wait_on(1, 1'b0, 2100, n);
    chk(n > 1900, 1'b1);
    wait_on(1, 1'b1, 40, n);
    chk(n >= REC - 2 && n <= REC + 2, 1'b1);
    wait_on(1, 1'b0, 2100, n);
    chk(n > 1900, 1'b1);
    @(posedge i_clk) shrt <= 1'b0;
    wait_on(1, 1'b1, 40, n);
    adv(100);
    chk(path.bat_fet_on, 1'b1);
    // inhibit cleared while off line, then a valid input arrives
    host_wr(1'b0);
    adv(1);
    chk(inh, 1'b0);
    set_vin(16'h1388);
    wait_on(0, 1'b1, 10, n);
    chk(path, exp_path(1'b0));
    wait_on(2, 1'b1, RES + 10, n);
    chk(n >= RES - 5 && n <= RES + 5, 1'b1);
    adv(1);
    chk(stat.state_code, SC_CHARGING);
    chk(term, 1'b1);
    // inhibit set while charging, then cleared again
    host_wr(1'b1);
    adv(3);
    chk(path, exp_path(1'b0));
    host_wr(1'b0);
    wait_on(2, 1'b1, 3, n);
    // request bit and disable pin each force high impedance
    for (k = 0; k < 2; k++) begin
      @(posedge i_clk);
      if (k == 0) hiz <= 1'b1;
      else cd <= 1'b1;
      wait_on(4, 1'b1, 6, n);
      adv(2);
      chk(path, exp_path(1'b1));
      @(posedge i_clk);
      {hiz, cd} <= 2'b00;
      wait_on(0, 1'b1, 8, n);
      wait_on(2, 1'b1, RES + 10, n);
      chk(n >= RES - 5 && n <= RES + 5, 1'b1);
    end
    // droop with a random timer option, applied at a rising edge
    rnd = xs();
    @(posedge i_clk) dbl <= rnd[0];
    set_vin(16'h1036);
    adv(6);
    chk({stat.droop_flag, cred}, 2'h3);
    chk({term, text}, {1'b0, dbl});
    // sleep: one pulse, fault code held until read after the cause is gone
    set_vin(16'h0F3C);
    wait_on(3, 1'b1, 8, n);
    chk(path[3:1], 3'h3);
    cnt_pulse(n);
    chk(n, PUL);
    adv(30);
    chk({spul, stat.state_code, stat.fault_code}, {1'b0, SC_FAULT, FC_SLEEP});
    host_rd();
    chk(stat.fault_code, FC_SLEEP);
    set_vin(16'h1388);
    wait_on(2, 1'b1, RES + 10, n);
    adv(1);
    chk(stat.state_code, SC_CHARGING);
    chk(stat.fault_code, FC_SLEEP);
    host_rd();
    chk(stat.fault_code, FC_NONE);
    // overvoltage: buck off at once, fault only after the deglitch
    set_vin(16'h3A98);
    wait_on(0, 1'b0, 4, n);
    adv(3000);
    chk(stat.fault_code, FC_NONE);
    wait_on(3, 1'b1, 1100, n);
    chk({stat.state_code, stat.fault_code, path[2:1]}, {SC_FAULT, FC_OVP, 2'h3});
    cnt_pulse(n);
    chk(n, PUL);
    set_vin(16'h1388);
    wait_on(2, 1'b1, 10, n);
    adv(1);
    chk(stat.state_code, SC_CHARGING);
    host_rd();
    chk(stat.fault_code, FC_NONE);
    // random valid supplies keep charging steady
    for (k = 0; k < 20; k++) begin
      set_vin(16'h10CC + 16'(xs() % 32'h1388));
      adv(6);
      chk({path.buck_en, stat.droop_flag, stat.state_code}, {2'h2, SC_CHARGING});
    end
    print_verdict();
  end
endmodule
